// ---- design/dcsm_pkg.sv ----
// Package: offsets, field positions, reset values and carriers for the dual-core semaphore block
package dcsm_pkg;
    // Register offsets on each core's register port
    localparam logic [7:0]  REG_SEM_OFF        = 8'h34;
    localparam logic [7:0]  REG_DATA_PAGE_OFF  = 8'h30;
    localparam logic [7:0]  REG_PROG_PAGE_OFF  = 8'h31;
    // Page select and semaphore reset values
    localparam logic [7:0]  DATA_PAGE_RST      = 8'h00;
    localparam logic [7:0]  PROG_PAGE_RST      = 8'h01;
    localparam logic [7:0]  SEM_RST            = 8'h00;
    // Shared memory placement
    localparam logic [23:0] SHM_BASE           = 24'h020000;
    localparam int          SHM_AW             = 12;
    localparam int          SHM_DW             = 16;
    // Semaphore field positions
    localparam int          SEM_FLAG0_BIT      = 0;
    localparam int          SEM_FLAG1_BIT      = 1;
    localparam int          SEM_IRQ_BIT        = 2;
    localparam int          SEM_LOCK_BIT       = 7;
    localparam int          SEM_IN_FLAG0_BIT   = 8;
    localparam int          SEM_IN_FLAG1_BIT   = 9;
    localparam int          SEM_IN_IRQ_BIT     = 10;
    localparam int          SEM_IN_LOCK_BIT    = 15;
    localparam logic [7:0]  SEM_WR_MASK        = 8'h87;
    // Idle cycles before ownership of the shared port is given up
    localparam logic [1:0]  RELEASE_IDLE       = 2'h2;

    typedef enum logic [2:0] {
        OWN_NONE = 3'b001,
        OWN_C0   = 3'b010,
        OWN_C1   = 3'b100
    } dcsm_owner_e;

    // One data-memory bus access from a core
    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dcsm_mreq_s;

    // One register port access from a core
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } dcsm_rreq_s;
endpackage : dcsm_pkg

// ---- design/dcsm_shared_ram.sv ----
// Single-port shared memory held in flip-flops, synchronous read and write
`timescale 1ns/100ps
`default_nettype none
module dcsm_shared_ram #(
    parameter int AW = 12,
    parameter int DW = 16
) (
    input  wire logic          i_clk,
    input  wire logic          i_en,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [DW-1:0] i_wdata,
    output logic      [DW-1:0] o_rdata
);
    logic [DW-1:0] mem_q [2**AW];

    // One internal port only: a single access per cycle
    always_ff @(posedge i_clk) begin
        if (i_en) begin
            if (i_we) begin
                mem_q[i_addr] <= i_wdata;
            end
            o_rdata <= mem_q[i_addr];
        end
    end
endmodule : dcsm_shared_ram
`default_nettype wire

// ---- design/dcsm_top.sv ----
// Dual-core shared memory arbiter and inter-core semaphore registers
//
// What this block does
// - Shared memory answers at 0x020000, page 2
// - Reached only over data bus with page select
// - Reset pages: data bus 0, program bus 1
// - Single port: stall requester while other uses it
// - A shared access takes one cycle, two when back to back
// - Owner keeps port until two idle cycles
// - Simultaneous requests: core zero wins first
// - Burst accesses after the first take two cycles
// - Semaphore register: flags 0,1, irq 2, lock 7
// - Output flags 0,1 appear as other's bits 8,9
// - Irq bit 2 interrupts other core, shows bit 10
// - Inter-core interrupt works in both directions
`timescale 1ns/100ps
`default_nettype none
module dcsm_top
    import dcsm_pkg::*;
#(
    parameter int AW = SHM_AW,
    parameter int DW = SHM_DW
) (
    input  wire logic             i_clk,
    input  wire logic             i_srst,
    input  wire logic       [1:0] i_mem_req,
    input  wire dcsm_mreq_s [1:0] i_mem,
    output logic            [1:0] o_mem_done,
    output logic         [DW-1:0] o_mem_rdata,
    output logic            [1:0] o_mem_stall,
    output logic            [1:0] o_shm_owner,
    input  wire dcsm_rreq_s [1:0] i_reg,
    output logic      [1:0][15:0] o_reg_rdata,
    output logic       [1:0][7:0] o_data_page,
    output logic       [1:0][7:0] o_prog_page,
    output logic            [1:0] o_irq
);
    dcsm_owner_e     owner_q;
    logic [1:0]      idle_q;
    logic [1:0]      done_q;
    logic [1:0]      stall_q;
    logic [1:0]      hit;
    logic [1:0]      grant;
    logic [1:0]      accept;
    logic            owner_active;
    logic [1:0][7:0] data_page_q;
    logic [1:0][7:0] prog_page_q;
    logic [1:0][7:0] sem_q;
    logic [1:0][15:0] sem_view;
    logic [1:0][15:0] rdata_q;
    logic            ram_en;
    logic            ram_we;
    logic [AW-1:0]   ram_addr;
    logic [DW-1:0]   ram_wdata;

    // Decode: data page plus bus address must fall inside the shared window
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            hit[c] = i_mem_req[c] && ({data_page_q[c], i_mem[c].addr} >= SHM_BASE)
                     && ({data_page_q[c], i_mem[c].addr} < SHM_BASE + 24'(2**AW));
        end
    end

    // Arbitration with fixed priority and sticky ownership
    always_comb begin
        grant = 2'b00;
        case (owner_q)
            OWN_NONE: begin
                if (hit[0]) begin
                    grant = 2'b01;
                end else if (hit[1]) begin
                    grant = 2'b10;
                end
            end
            OWN_C0:   grant = 2'b01;
            OWN_C1:   grant = 2'b10;
            default:  grant = 2'b00;
        endcase
    end

    // A core still in its done cycle may not start again, so back-to-back accesses cost two cycles
    assign accept = grant & hit & ~done_q;

    always_comb begin
        case (owner_q)
            OWN_C0:  owner_active = hit[0];
            OWN_C1:  owner_active = hit[1];
            default: owner_active = 1'b0;
        endcase
    end

    // Ownership register and idle counter
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            owner_q <= OWN_NONE;
            idle_q  <= 2'h0;
        end else begin
            case (owner_q)
                OWN_NONE: begin
                    idle_q <= 2'h0;
                    if (accept[0]) begin
                        owner_q <= OWN_C0;
                    end else if (accept[1]) begin
                        owner_q <= OWN_C1;
                    end
                end
                OWN_C0, OWN_C1: begin
                    if (owner_active) begin
                        idle_q <= 2'h0;
                    end else if (idle_q + 2'h1 >= RELEASE_IDLE) begin
                        idle_q  <= 2'h0;
                        owner_q <= OWN_NONE;
                    end else begin
                        idle_q <= idle_q + 2'h1;
                    end
                end
                default: begin
                    owner_q <= OWN_NONE;
                    idle_q  <= 2'h0;
                end
            endcase
        end
    end

    // Done pulse one cycle after acceptance; the wait is the synchronisation stall
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            done_q  <= 2'b00;
            stall_q <= 2'b00;
        end else begin
            done_q  <= accept;
            stall_q <= hit & ~accept & ~done_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_shm_owner <= 2'b00;
        end else begin
            o_shm_owner <= {owner_q == OWN_C1, owner_q == OWN_C0};
        end
    end

    // Memory port mux: at most one accept per cycle
    always_comb begin
        ram_en    = |accept;
        ram_we    = accept[1] ? i_mem[1].we : i_mem[0].we;
        ram_addr  = accept[1] ? i_mem[1].addr[AW-1:0] : i_mem[0].addr[AW-1:0];
        ram_wdata = accept[1] ? i_mem[1].wdata[DW-1:0] : i_mem[0].wdata[DW-1:0];
    end

    dcsm_shared_ram #(
        .AW (AW),
        .DW (DW)
    ) u_ram (
        .i_clk   (i_clk),
        .i_en    (ram_en),
        .i_we    (ram_we),
        .i_addr  (ram_addr),
        .i_wdata (ram_wdata),
        .o_rdata (o_mem_rdata)
    );

    // Page select registers, one pair per core
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            for (int c = 0; c < 2; c++) begin
                data_page_q[c] <= DATA_PAGE_RST;
                prog_page_q[c] <= PROG_PAGE_RST;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (i_reg[c].wr && i_reg[c].addr == REG_DATA_PAGE_OFF) begin
                    data_page_q[c] <= i_reg[c].wdata[7:0];
                end else if (i_reg[c].wr && i_reg[c].addr == REG_PROG_PAGE_OFF) begin
                    prog_page_q[c] <= i_reg[c].wdata[7:0];
                end
            end
        end
    end

    // Semaphore outputs; writes of zero clear the far side's view, reserved bits stay zero
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            for (int c = 0; c < 2; c++) begin
                sem_q[c] <= SEM_RST;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (i_reg[c].wr && i_reg[c].addr == REG_SEM_OFF) begin
                    sem_q[c] <= i_reg[c].wdata[7:0] & SEM_WR_MASK;
                end
            end
        end
    end

    // Read view: own outputs low, other core's outputs as inputs high
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            sem_view[c]                   = {8'h00, sem_q[c]};
            sem_view[c][SEM_IN_FLAG0_BIT] = sem_q[1-c][SEM_FLAG0_BIT];
            sem_view[c][SEM_IN_FLAG1_BIT] = sem_q[1-c][SEM_FLAG1_BIT];
            sem_view[c][SEM_IN_IRQ_BIT]   = sem_q[1-c][SEM_IRQ_BIT];
            sem_view[c][SEM_IN_LOCK_BIT]  = sem_q[1-c][SEM_LOCK_BIT];
        end
    end

    // Register read data, captured on the read strobe
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            for (int c = 0; c < 2; c++) begin
                rdata_q[c] <= 16'h0000;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (i_reg[c].rd) begin
                    if (i_reg[c].addr == REG_SEM_OFF) begin
                        rdata_q[c] <= sem_view[c];
                    end else if (i_reg[c].addr == REG_DATA_PAGE_OFF) begin
                        rdata_q[c] <= {8'h00, data_page_q[c]};
                    end else if (i_reg[c].addr == REG_PROG_PAGE_OFF) begin
                        rdata_q[c] <= {8'h00, prog_page_q[c]};
                    end else begin
                        rdata_q[c] <= 16'h0000;
                    end
                end
            end
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_mem_done  = done_q;
    assign o_mem_stall = stall_q;
    assign o_data_page = data_page_q;
    assign o_prog_page = prog_page_q;
    // Masking and global enable live in the receiving core, not here
    assign o_irq       = {sem_q[0][SEM_IRQ_BIT], sem_q[1][SEM_IRQ_BIT]};
endmodule : dcsm_top
`default_nettype wire

// ---- testbench/dcsm_properties.sv ----
// Port-level checks for the shared memory arbiter and semaphores
`timescale 1ns/100ps
`default_nettype none
module dcsm_checker
    import dcsm_pkg::*;
(
    input wire logic             i_clk,
    input wire logic             i_srst,
    input wire logic       [1:0] i_mem_req,
    input wire dcsm_mreq_s [1:0] i_mem,
    input wire logic       [1:0] o_mem_done,
    input wire logic       [1:0] o_shm_owner,
    input wire dcsm_rreq_s [1:0] i_reg,
    input wire logic [1:0][15:0] o_reg_rdata,
    input wire logic  [1:0][7:0] o_data_page,
    input wire logic  [1:0][7:0] o_prog_page,
    input wire logic       [1:0] o_irq
);
    logic hit0;
    // Out-of-window requests count as idle for ownership
    assign hit0 = i_mem_req[0] && o_data_page[0] == 8'h02 && i_mem[0].addr[15:12] == 4'h0;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    one_done_a: assert property (!(o_mem_done[0] && o_mem_done[1])) else $error("two dones");
    sync_stall_a: assert property (o_mem_done[1] |-> i_mem_req[1] && $past(i_mem_req[1]))
        else $error("short access");
    burst_gap_a: assert property (o_mem_done[0] |=> !o_mem_done[0]) else $error("done twice");
    one_owner_a: assert property (o_shm_owner != 2'b11) else $error("two owners");
    // The owner flag trails ownership by one cycle, so the two idle cycles are samples 2 and 3 back; the check looks at samples 1 and 2
    idle_release_a: assert property ($fell(o_shm_owner[0]) |-> !$past(hit0, 1) && !$past(hit0, 2))
        else $error("early release");
    prog_reset_a: assert property ($fell(i_srst) |-> o_prog_page == 16'h0101) else $error("prog page");
    irq_raise_a: assert property (i_reg[0].wr && i_reg[0].addr == REG_SEM_OFF && i_reg[0].wdata[2]
        |-> ##[1:2] o_irq[1]) else $error("irq low");
    irq_clear_a: assert property (i_reg[1].wr && i_reg[1].addr == REG_SEM_OFF && !i_reg[1].wdata[2]
        |-> ##[1:2] !o_irq[0]) else $error("irq high");
    unmapped_a: assert property (i_reg[0].rd && !(i_reg[0].addr inside {8'h30, 8'h31, 8'h34})
        |=> o_reg_rdata[0] == 16'h0000) else $error("unmapped data");
endmodule : dcsm_checker
bind dcsm_top dcsm_checker chk_u (.i_clk(i_clk), .i_srst(i_srst), .i_mem_req(i_mem_req), .i_mem(i_mem),
    .o_mem_done(o_mem_done), .o_shm_owner(o_shm_owner), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata),
    .o_data_page(o_data_page), .o_prog_page(o_prog_page), .o_irq(o_irq));
`default_nettype wire

// ---- testbench/dcsm_core_model.sv ----
// Far core model: one held shared-memory request and interrupt servicing
`timescale 1ns/100ps
`default_nettype none
module dcsm_core_model
    import dcsm_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_go,
    input  wire dcsm_mreq_s  i_acc,
    input  wire logic        i_done,
    input  wire logic        i_irq,
    input  wire logic [15:0] i_mask,
    input  wire logic        i_gie,
    output logic             o_req,
    output dcsm_mreq_s       o_mem,
    output logic             o_serve
);
    initial begin
        o_req = 1'b0;
        o_mem = '0;
    end
    // Request held until done is sampled; released bus shows no stale value
    always @(posedge i_clk) begin
        if (i_go) begin
            o_req <= 1'b1;
            o_mem <= i_acc;
        end else if (i_done) begin
            o_req <= 1'b0;
            o_mem <= ~o_mem;
        end
    end
    assign o_serve = i_irq && i_mask[8] && i_gie;
endmodule : dcsm_core_model
`default_nettype wire

// ---- testbench/dcsm_top_bench.sv ----
// Self-checking bench for the shared memory arbiter and semaphore registers
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module dcsm_top_bench
    import dcsm_pkg::*;
;
    logic             i_clk = 1'b0;
    logic             i_srst = 1'b1;
    logic             c0_req, p_req, go, gie, srv;
    dcsm_mreq_s       c0_mem, p_mem, acc;
    logic       [1:0] done, stall, own, irq;
    logic      [15:0] rdata, mask, v;
    dcsm_rreq_s [1:0] rg;
    logic [1:0][15:0] rrd;
    logic  [1:0][7:0] dpg, ppg;
    logic      [31:0] seed = 32'h72567E1C;
    logic      [31:0] x;
    logic      [15:0] mdl [int];
    logic      [11:0] aq [$];
    int               sb [4] = '{0, 1, 2, 7};
    int               fail_count, num_checks, n, d0, d1, st1;
    dcsm_top dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_mem_req({p_req, c0_req}), .i_mem({p_mem, c0_mem}),
        .o_mem_done(done), .o_mem_rdata(rdata), .o_mem_stall(stall), .o_shm_owner(own), .i_reg(rg),
        .o_reg_rdata(rrd), .o_data_page(dpg), .o_prog_page(ppg), .o_irq(irq));
    dcsm_core_model far_u (.i_clk(i_clk), .i_go(go), .i_acc(acc), .i_done(done[1]), .i_irq(irq[1]),
        .i_mask(mask), .i_gie(gie), .o_req(p_req), .o_mem(p_mem), .o_serve(srv));
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        d0 <= d0 + done[0];
        d1 <= d1 + done[1];
        st1 <= st1 + stall[1];
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic tick(int k = 1);
        repeat (k) @(posedge i_clk);
        #1;
    endtask : tick
    task automatic summarize();
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    task automatic reg_io(int k, logic w, logic [7:0] a, logic [15:0] d);
        rg[k] = {w, !w, a, d};
        tick();
        rg[k] = '0;
        v = rrd[k];
        tick();
    endtask : reg_io
    // Keep leaves the request up so the next access follows in the done cycle
    task automatic mem_io(logic we, logic [11:0] a, bit keep);
        logic [31:0] r;
        r = rnd();
        c0_req = 1'b1;
        c0_mem = {we, 4'h0, a, r[15:0]};
        n = 0;
        do begin
            tick();
            n++;
        end while (done[0] !== 1'b1 && n < 50);
        if (n == 50) begin
            fail_count++;
            summarize();
        end
        if (we)
            mdl[a] = r[15:0];
        else
            `CHK("rdata", mdl[a], rdata)
        if (!keep) begin
            c0_req = 1'b0;
            c0_mem = ~c0_mem;
        end
    endtask : mem_io
    initial begin
        c0_req = 1'b0;
        c0_mem = '0;
        go = 1'b0;
        acc = '0;
        rg = '0;
        mask = 16'h0100;
        gie = 1'b1;
        tick(16);
        i_srst = 1'b0;
        `CHK("data_page", dpg, 16'h0000)
        `CHK("prog_page", ppg, 16'h0101)
        for (int k = 0; k < 2; k++)
            reg_io(k, 1'b1, REG_DATA_PAGE_OFF, 16'h0002);
        `CHK("page_set", dpg, 16'h0202)
        for (int i = 0; i < 16; i++) begin
            x = rnd();
            if (i < 8)
                aq.push_back(x[11:0]);
            mem_io(i < 8, aq[i % 8], i < 15);
            `CHK("latency", n, (i == 0) ? 1 : 2)
        end
        tick();
        c0_req = 1'b1;
        c0_mem = {1'b0, 16'h1000, 16'h0000};
        n = d0;
        tick(8);
        `CHK("outside", d0, n)
        c0_req = 1'b0;
        tick(4);
        x = rnd();
        go = 1'b1;
        acc = {1'b1, 16'h0020, x[31:16]};
        mdl[32] = x[31:16];
        tick();
        go = 1'b0;
        mem_io(1'b1, aq[0], 1'b0);
        `CHK("first_lat", n, 1)
        `CHK("first_wins", d1, 0)
        for (n = 0; n < 50 && d1 == 0; n++)
            tick();
        `CHK("c1_done", d1, 1)
        `CHK("c1_stall", st1 > 0, 1)
        mem_io(1'b0, 12'h020, 1'b0);
        `CHK("held", n > 2, 1)
        for (int k = 0; k < 2; k++)
            foreach (sb[j]) begin
                reg_io(k, 1'b1, REG_SEM_OFF, 16'h0001 << sb[j]);
                reg_io(1 - k, 1'b0, REG_SEM_OFF, 16'h0000);
                `CHK("sem_in", v, 16'h0001 << (sb[j] == 7 ? 15 : sb[j] + 8))
                `CHK("irq", irq[1 - k], sb[j] == 2)
                reg_io(k, 1'b1, REG_SEM_OFF, 16'h0000);
                reg_io(1 - k, 1'b0, REG_SEM_OFF, 16'h0000);
                `CHK("sem_clr", v, 16'h0000)
            end
        reg_io(0, 1'b1, REG_SEM_OFF, 16'hFFFF);
        reg_io(0, 1'b0, REG_SEM_OFF, 16'h0000);
        `CHK("sem_own", v, 16'h0087)
        reg_io(1, 1'b0, REG_SEM_OFF, 16'h0000);
        `CHK("sem_far", v, 16'h8700)
        `CHK("serve", srv, 1'b1)
        mask = 16'h0000;
        reg_io(0, 1'b0, 8'h55, 16'h0000);
        `CHK("unmapped", v, 16'h0000)
        `CHK("masked", srv, 1'b0)
        summarize();
    end
endmodule : dcsm_top_bench
`default_nettype wire
